/* File: rtl/trx_pkg.sv */
// Package: register offsets, field positions, reset values and timing constants
package trx_pkg;
    // Register addresses on the serial port (6-bit address space)
    localparam int unsigned  ADDR_W          = 6;
    localparam logic [5:0]   ADDR_CONTROL    = 6'h01;
    localparam logic [5:0]   ADDR_CONFIG0    = 6'h02;
    localparam logic [5:0]   ADDR_CONFIG1    = 6'h03;
    localparam logic [5:0]   ADDR_STATUS     = 6'h1a;

    // Control register fields
    localparam int unsigned  CTL_AGC_LOCK    = 7;
    localparam int unsigned  CTL_GAIN        = 6;
    localparam int unsigned  CTL_TRACK       = 5;
    localparam int unsigned  CTL_POLL_TIMER_CAL_START        = 3;
    localparam int unsigned  CTL_FSK_CAL_START        = 2;
    localparam int unsigned  CTL_CLKOUT      = 1;
    localparam int unsigned  CTL_SLEEP       = 0;
    localparam logic [7:0]   CTL_WMASK       = 8'hef;

    // Configuration 0 fields
    localparam int unsigned  CF0_FSK         = 7;
    localparam int unsigned  CF0_TX          = 6;
    localparam int unsigned  CF0_MANUAL_GAIN_ENABLE       = 5;
    localparam int unsigned  CF0_DRX         = 4;
    localparam int unsigned  CF0_OFF_LO      = 2;
    localparam int unsigned  CF0_ON_LO       = 0;

    // Configuration 1 fields
    localparam int unsigned  CF1_AUTO_FSK_CAL_ENABLE        = 6;
    localparam int unsigned  CF1_CONT_CLK    = 5;
    localparam int unsigned  CF1_DIV_LO      = 3;
    localparam int unsigned  CF1_DWELL_LO    = 0;
    localparam logic [7:0]   CF1_WMASK       = 8'h7f;

    // Status fields
    localparam int unsigned  ST_LOCKED       = 7;
    localparam int unsigned  ST_GAIN         = 6;
    localparam int unsigned  ST_XTAL         = 5;
    localparam int unsigned  ST_POLL_TIMER_CAL_DONE        = 1;
    localparam int unsigned  ST_FSK_CAL_DONE        = 0;

    // Reset values
    localparam logic [7:0]   RST_CONTROL     = 8'h00;
    localparam logic [7:0]   RST_CONFIG0     = 8'h00;
    localparam logic [7:0]   RST_CONFIG1     = 8'h00;

    // Dwell exponent: K = 9 + 2*code
    localparam int unsigned  DWELL_K_BASE    = 9;

    // Calibration durations
    localparam int unsigned  POLL_TIMER_CAL_START_TIME_US    = 100;
    localparam int unsigned  FSK_CAL_START_TIME_US    = 50;
    localparam int unsigned  CLK_MHZ         = 20;
    localparam int unsigned  POLL_TIMER_CAL_START_CYCLES     = POLL_TIMER_CAL_START_TIME_US * CLK_MHZ;
    localparam int unsigned  FSK_CAL_START_CYCLES     = FSK_CAL_START_TIME_US * CLK_MHZ;
endpackage : trx_pkg

/* File: rtl/trx_regs.sv */
// Transceiver control, configuration and status register bank
//
// Overview of operation
// - Control bit 7 enables the AGC lock feature.
// - Control bit 6 forces high or low gain only in manual gain mode.
// - Control bit 5 forces peak detectors into manual tracking.
// - Writing control bit 3 starts polling-timer calibration; bit self-clears when done.
// - Writing control bit 2 starts FSK calibration; bit self-clears when done.
// - Control bit 1 enables the crystal clock output.
// - Control bit 0 forces deep sleep, overriding the enable pin.
// - Config-0 bit 7 selects FSK (1) or ASK (0) both directions.
// - Config-0 bit 6 forces transmit; else receive while transmit/receive pin low.
// - Config-0 bit 5 enables manual gain mode.
// - Config-0 bit 4 enables discontinuous receive; bits 3:2 off-timer prescaler.
// - Config-0 bits 1:0 select the on-timer prescaler.
// - Config-1 bit 6 auto-runs FSK calibration on each wake in discontinuous mode.
// - Config-1 bit 5 keeps clock output continuous; else gated by on time or enable.
// - Config-1 bits 4:3 select the clock-output divider, bit 4 MSB.
// - Status is read-only; bits 4 to 2 read zero.
// - Status bit 7 shows PLL lock; unlocked blocks receive and transmit.
// - Status bit 6 shows present LNA gain state.
// - Status bit 5 shows a valid crystal clock.
// - Status bit 1 reads 1 once polling-timer calibration completed.
// - Status bit 0 reads 1 once FSK calibration completed.
// - Clock output is 0 when disabled; codes 0..3 divide by 1, 2, 4, 8.
// - Dwell exponent K is 9 plus twice the code, 9 to 23.
`timescale 1ns/1ps
`default_nettype none
module trx_regs
    import trx_pkg::*;
#(
    parameter int unsigned POLL_TIMER_CAL_START_CYC = trx_pkg::POLL_TIMER_CAL_START_CYCLES,
    parameter int unsigned FSK_CAL_START_CYC = trx_pkg::FSK_CAL_START_CYCLES
) (
    // Clock, reset, enable
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        ce,
    // Register port
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    input  wire logic [trx_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    output logic      [7:0]                  reg_rdata,
    // Pins and analog status (asynchronous)
    input  wire logic                        enable_pin,
    input  wire logic                        tx_rx_pin,
    input  wire logic                        pll_lock_in,
    input  wire logic                        xtal_ok_in,
    // Crystal-clock tick and DISCONTINUOUS_RX_ENABLE timing from the sequencer
    input  wire logic                        xtal_tick,
    input  wire logic                        drx_on_time,
    input  wire logic                        drx_wake,
    input  wire logic                        agc_high_req,
    // Analog controls
    output logic                             agc_lock_enable,
    output logic                             peak_track_force,
    output logic                             lna_high_gain,
    output logic                             deep_sleep,
    output logic                             fsk_mode,
    output logic                             tx_mode,
    output logic                             rx_mode,
    output logic                             manual_gain_enable,
    output logic                             discontinuous_rx_enable,
    output logic      [1:0]                  off_prescale,
    output logic      [1:0]                  on_prescale,
    output logic      [4:0]                  dwell_exponent,
    output logic                             poll_cal_busy,
    output logic                             fsk_cal_busy,
    output logic                             clock_out
);
    import trx_pkg::*;

    // Refuse calibration lengths that the 16-bit counters cannot hold
    if (POLL_TIMER_CAL_START_CYC < 1 || POLL_TIMER_CAL_START_CYC > 65535 || FSK_CAL_START_CYC < 1 || FSK_CAL_START_CYC > 65535)
    begin : g_bad_cal
        $error("calibration cycle counts out of range");
    end

    // Register storage, timers and internal strobes
    logic [7:0]  control_r;
    logic [7:0]  config0_r;
    logic [7:0]  config1_r;
    logic        poll_timer_cal_start_done_r;
    logic        fsk_cal_start_done_r;
    logic [15:0] poll_timer_cal_start_cnt_r;
    logic [15:0] fsk_cal_start_cnt_r;
    logic [2:0]  div_cnt_r;
    logic [3:0]  pins;
    logic        wr_ctl;
    logic        poll_timer_cal_start_fin;
    logic        fsk_cal_start_fin;
    logic        fsk_cal_start_auto;
    logic        div_bit;
    logic        clk_gate;

    // Pin synchronisers: enable, tx/rx, lock, crystal alive
    trx_sync3 #(.W(4)) u_sync (
        .clk    (clk),
        .rstn   (rstn),
        .ce     (ce),
        .pin_in ({enable_pin, tx_rx_pin, pll_lock_in, xtal_ok_in}),
        .level  (pins)
    );

    // Write strobe, calibration finish and automatic start decodes
    assign wr_ctl    = reg_wr && (reg_addr == ADDR_CONTROL);
    assign poll_timer_cal_start_fin  = control_r[CTL_POLL_TIMER_CAL_START] && (poll_timer_cal_start_cnt_r == 16'(POLL_TIMER_CAL_START_CYC - 1));
    assign fsk_cal_start_fin  = control_r[CTL_FSK_CAL_START] && (fsk_cal_start_cnt_r == 16'(FSK_CAL_START_CYC - 1));
    assign fsk_cal_start_auto = config1_r[CF1_AUTO_FSK_CAL_ENABLE] && config0_r[CF0_DRX] && drx_wake;

    // Control register; calibration bits self-clear on finish, write of 1 wins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            control_r <= RST_CONTROL;
        else if (ce)
        begin
            if (wr_ctl)
                control_r <= reg_wdata & CTL_WMASK;
            else
            begin
                if (poll_timer_cal_start_fin)
                    control_r[CTL_POLL_TIMER_CAL_START] <= 1'b0;
                if (fsk_cal_start_fin)
                    control_r[CTL_FSK_CAL_START] <= 1'b0;
            end
            // A wake request wins over a host clear or a finish in one cycle
            if (fsk_cal_start_auto)
                control_r[CTL_FSK_CAL_START] <= 1'b1;
        end
    end

    // Configuration registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            config0_r <= RST_CONFIG0;
            config1_r <= RST_CONFIG1;
        end
        else if (ce && reg_wr)
        begin
            if (reg_addr == ADDR_CONFIG0)
                config0_r <= reg_wdata;
            if (reg_addr == ADDR_CONFIG1)
                config1_r <= reg_wdata & CF1_WMASK;
        end
    end

    // Calibration timers; done flags clear on start, set on finish
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            poll_timer_cal_start_cnt_r  <= 16'h0000;
            fsk_cal_start_cnt_r  <= 16'h0000;
            poll_timer_cal_start_done_r <= 1'b0;
            fsk_cal_start_done_r <= 1'b0;
        end
        else if (ce)
        begin
            if (control_r[CTL_POLL_TIMER_CAL_START] && !poll_timer_cal_start_fin)
                poll_timer_cal_start_cnt_r <= poll_timer_cal_start_cnt_r + 16'h0001;
            else
                poll_timer_cal_start_cnt_r <= 16'h0000;
            if (control_r[CTL_FSK_CAL_START] && !fsk_cal_start_fin)
                fsk_cal_start_cnt_r <= fsk_cal_start_cnt_r + 16'h0001;
            else
                fsk_cal_start_cnt_r <= 16'h0000;
            if (poll_timer_cal_start_fin)
                poll_timer_cal_start_done_r <= 1'b1;
            else if (control_r[CTL_POLL_TIMER_CAL_START])
                poll_timer_cal_start_done_r <= 1'b0;
            if (fsk_cal_start_fin)
                fsk_cal_start_done_r <= 1'b1;
            else if (control_r[CTL_FSK_CAL_START])
                fsk_cal_start_done_r <= 1'b0;
        end
    end

    // Read data register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (ce && reg_rd)
        begin
            case (reg_addr)
                ADDR_CONTROL: reg_rdata <= control_r;
                ADDR_CONFIG0: reg_rdata <= config0_r;
                ADDR_CONFIG1: reg_rdata <= config1_r;
                ADDR_STATUS:  reg_rdata <= {pins[1], lna_high_gain, pins[0], 3'b000,
                                            poll_timer_cal_start_done_r, fsk_cal_start_done_r};
                default:      reg_rdata <= 8'h00;
            endcase
        end
    end

    // Control-register levels to the analog side
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            agc_lock_enable  <= 1'b0;
            peak_track_force <= 1'b0;
            deep_sleep       <= 1'b0;
            poll_cal_busy    <= 1'b0;
            fsk_cal_busy     <= 1'b0;
        end
        else if (ce)
        begin
            agc_lock_enable  <= control_r[CTL_AGC_LOCK];
            peak_track_force <= control_r[CTL_TRACK];
            // Sleep bit overrides the enable pin
            deep_sleep       <= control_r[CTL_SLEEP] || !pins[3];
            poll_cal_busy    <= control_r[CTL_POLL_TIMER_CAL_START];
            fsk_cal_busy     <= control_r[CTL_FSK_CAL_START];
        end
    end

    // LNA gain: forced in manual mode, otherwise the AGC decision
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lna_high_gain <= 1'b0;
        else if (ce)
        begin
            if (config0_r[CF0_MANUAL_GAIN_ENABLE])
                lna_high_gain <= control_r[CTL_GAIN];
            else
                lna_high_gain <= agc_high_req;
        end
    end

    // Modulation and direction; no data path while the PLL is unlocked
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fsk_mode           <= 1'b0;
            tx_mode            <= 1'b0;
            rx_mode            <= 1'b0;
            manual_gain_enable <= 1'b0;
        end
        else if (ce)
        begin
            fsk_mode           <= config0_r[CF0_FSK];
            tx_mode            <= pins[1] && (config0_r[CF0_TX] || pins[2]);
            rx_mode            <= pins[1] && !config0_r[CF0_TX] && !pins[2];
            manual_gain_enable <= config0_r[CF0_MANUAL_GAIN_ENABLE];
        end
    end

    // Discontinuous-receive timing selects and AGC dwell exponent
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            discontinuous_rx_enable <= 1'b0;
            off_prescale            <= 2'b00;
            on_prescale             <= 2'b00;
            dwell_exponent          <= 5'(DWELL_K_BASE);
        end
        else if (ce)
        begin
            discontinuous_rx_enable <= config0_r[CF0_DRX];
            off_prescale            <= config0_r[CF0_OFF_LO +: 2];
            on_prescale             <= config0_r[CF0_ON_LO +: 2];
            dwell_exponent          <= 5'(DWELL_K_BASE) + {1'b0, config1_r[CF1_DWELL_LO +: 3], 1'b0};
        end
    end

    // Clock-output divider on the crystal tick
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            div_cnt_r <= 3'b000;
        else if (ce && xtal_tick)
            div_cnt_r <= div_cnt_r + 3'b001;
    end

    // Divider tap per code; code zero passes the tick itself
    always_comb
    begin
        case (config1_r[CF1_DIV_LO +: 2])
            2'b00:   div_bit = xtal_tick;
            2'b01:   div_bit = div_cnt_r[0];
            2'b10:   div_bit = div_cnt_r[1];
            default: div_bit = div_cnt_r[2];
        endcase
    end

    // Gate: continuous, else DISCONTINUOUS_RX_ENABLE on window or enable pin
    assign clk_gate = config1_r[CF1_CONT_CLK] ||
                      (config0_r[CF0_DRX] ? drx_on_time : pins[3]);

    // Clock output pin; held low when disabled
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            clock_out <= 1'b0;
        else if (ce)
            clock_out <= control_r[CTL_CLKOUT] && clk_gate && div_bit;
    end
endmodule : trx_regs
`default_nettype wire

/* File: rtl/trx_sync3.sv */
// Three-stage synchroniser with agreement filter for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module trx_sync3 #(
    parameter int unsigned W = 4
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          ce,
    // Pin side
    input  wire logic [W-1:0]  pin_in,
    // Filtered level
    output logic      [W-1:0]  level
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // Per-bit chain; level moves only when stages two and three agree
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                s1_r[i]  <= 1'b0;
                s2_r[i]  <= 1'b0;
                s3_r[i]  <= 1'b0;
                level[i] <= 1'b0;
            end
            else if (ce)
            begin
                s1_r[i] <= pin_in[i];
                s2_r[i] <= s1_r[i];
                s3_r[i] <= s2_r[i];
                if (s2_r[i] == s3_r[i])
                    level[i] <= s3_r[i];
            end
        end
    end
endmodule : trx_sync3
`default_nettype wire

/* File: tb/transceiver_control_status_regs_bench.sv */
// Testbench: register bank against a behavioural register model
`timescale 1ns/1ps
`default_nettype none
module transceiver_control_status_regs_bench;
    import trx_pkg::*;
    // Design signals
    logic       clk = 1'b0;
    logic       rstn, ce, enable_pin, tx_rx_pin, pll_lock_in, xtal_ok_in;
    logic       xtal_tick, drx_on_time, drx_wake, agc_high_req, reg_wr, reg_rd;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic       agc_lock_enable, peak_track_force, lna_high_gain, deep_sleep, fsk_mode;
    logic       tx_mode, rx_mode, manual_gain_enable, discontinuous_rx_enable, clock_out;
    logic [1:0] off_prescale, on_prescale;
    logic [4:0] dwell_exponent;
    logic       poll_cal_busy, fsk_cal_busy;
    // Model and counters
    logic [7:0] m [1:3];
    logic [7:0] v;
    logic [5:0] a;
    int         error_cnt, checks_done, i, k, n, e;

    trx_regs #(.POLL_TIMER_CAL_START_CYC(10), .FSK_CAL_START_CYC(8)) uut (.*);
    trx_host_model host (.*);

    // Clock and crystal tick every other cycle
    always #25 clk = ~clk;
    always @(negedge clk) xtal_tick <= rstn & ~xtal_tick;

    task automatic chk(input logic [7:0] got, input logic [7:0] ex);
        checks_done++;
        if (got !== ex)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, ex);
        end
    endtask : chk

    task automatic rdchk(input logic [5:0] ad, input logic [7:0] ex);
        logic [7:0] got;
        host.rd(ad, got);
        chk(got, ex);
    endtask : rdchk

    task automatic cal_wait();
        for (k = 0; k < 40 && (poll_cal_busy !== 1'b0 || fsk_cal_busy !== 1'b0); k++) @(negedge clk);
        chk({7'h0, poll_cal_busy | fsk_cal_busy}, 8'h00);
    endtask : cal_wait

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    // Watchdog
    initial
    begin
        #300000;
        error_cnt++;
        close_out();
    end

    // Test sequence
    initial
    begin
        {ce, enable_pin, pll_lock_in, xtal_ok_in} = 4'hf;
        {rstn, tx_rx_pin, drx_on_time, drx_wake, agc_high_req} = 5'h00;
        {error_cnt, checks_done} = 0;
        m = '{8'h00, 8'h00, 8'h00};
        void'($urandom(58830));
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        for (i = 1; i < 4; i++) rdchk(6'(i), 8'h00);
        rdchk(ADDR_STATUS, 8'ha0);
        $display("Test reset done");
        // Host-started calibrations self-clear
        host.wr(ADDR_CONTROL, 8'h0c);
        rdchk(ADDR_CONTROL, 8'h0c);
        rdchk(ADDR_STATUS, 8'ha0);
        cal_wait();
        rdchk(ADDR_CONTROL, 8'h00);
        rdchk(ADDR_STATUS, 8'ha3);
        // Wake in discontinuous mode starts calibration
        host.wr(ADDR_CONFIG0, 8'h10);
        host.wr(ADDR_CONFIG1, 8'h40);
        drx_wake = 1'b1;
        @(negedge clk);
        drx_wake = 1'b0;
        repeat (2) @(negedge clk);
        chk({7'h0, fsk_cal_busy}, 8'h01);
        cal_wait();
        $display("Test calibration done");
        // Manual gain forcing, and no effect outside manual mode
        host.wr(ADDR_CONFIG0, 8'h20);
        for (i = 0; i < 2; i++)
        begin
            host.wr(ADDR_CONTROL, {1'b0, 1'(i), 6'h00});
            rdchk(ADDR_STATUS, {1'b1, 1'(i), 6'h23});
        end
        host.wr(ADDR_CONFIG0, 8'h00);
        rdchk(ADDR_STATUS, 8'ha3);
        agc_high_req = 1'b1;
        rdchk(ADDR_STATUS, 8'he3);
        agc_high_req = 1'b0;
        // Model follows the registers left by the earlier tests
        m = '{8'h40, 8'h00, 8'h40};
        $display("Test gain done");
        // Random writes, refused writes and unmapped reads
        for (i = 0; i < 16; i++)
        begin
            n = $urandom_range(1, 4);
            a = (n == 4) ? ADDR_STATUS : 6'(n);
            v = 8'($urandom) & 8'hf3;
            host.wr(a, v);
            if (n < 4)
                m[n] = v & ((n == 1) ? CTL_WMASK : (n == 3) ? CF1_WMASK : 8'hff);
            rdchk((n < 4) ? a : 6'h3f, (n < 4) ? m[n] : 8'h00);
            host.rd(ADDR_STATUS, v);
            chk(v & 8'hbf, 8'ha3);
            chk({3'h0, dwell_exponent}, 8'd9 + {4'h0, m[3][2:0], 1'b0});
            chk({fsk_mode, manual_gain_enable, discontinuous_rx_enable, deep_sleep, agc_lock_enable,
                peak_track_force, on_prescale},
                {m[2][7], m[2][5:4], m[1][0], m[1][7], m[1][5], m[2][1:0]});
            chk({6'h0, tx_mode, rx_mode}, {6'h0, m[2][6], !m[2][6]});
        end
        $display("Test random done");
        // Clock output divider codes, then disabled
        for (i = 0; i < 4; i++)
        begin
            host.wr(ADDR_CONFIG1, {3'b001, 2'(i), 3'h0});
            host.wr(ADDR_CONTROL, 8'h02);
            repeat (4) @(negedge clk);
            k = 0;
            e = 32 >> i;
            for (n = 0; n < 64; n++)
            begin
                v[0] = clock_out;
                @(negedge clk);
                k += (clock_out === 1'b1 && v[0] === 1'b0);
            end
            if (k >= e - 1 && k <= e + 1)
                k = e;
            chk(8'(k), 8'(e));
        end
        // Gated clock: continuous bit clear, runs only in the DISCONTINUOUS_RX_ENABLE on window
        host.wr(ADDR_CONFIG1, 8'h00);
        host.wr(ADDR_CONFIG0, 8'h10);
        for (i = 0; i < 2; i++)
        begin
            drx_on_time = 1'(i);
            repeat (3) @(negedge clk);
            k = 0;
            for (n = 0; n < 16; n++)
            begin
                @(negedge clk);
                k += (clock_out === 1'b1);
            end
            chk(8'(k), 8'(8 * i));
        end
        drx_on_time = 1'b0;
        host.wr(ADDR_CONTROL, 8'h00);
        repeat (3) @(negedge clk);
        k = 0;
        for (n = 0; n < 16; n++)
        begin
            @(negedge clk);
            k += (clock_out !== 1'b0);
        end
        chk(8'(k), 8'h00);
        $display("Test clock output done");
        close_out();
    end
endmodule : transceiver_control_status_regs_bench
`default_nettype wire

/* File: tb/trx_host_model.sv */
// Host model: single-byte register reads and writes
`timescale 1ns/1ps
`default_nettype none
module trx_host_model (
    // Clock
    input  wire logic       clk,
    // Register port
    output var logic        reg_wr,
    output var logic        reg_rd,
    output var logic [5:0]  reg_addr,
    output var logic [7:0]  reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // Idle port
    initial
    begin
        {reg_wr, reg_rd} = 2'h0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
    end
    // One-cycle write; released lines show inverted values
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    // One-cycle read; data taken after the sampling edge
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : rd
endmodule : trx_host_model
`default_nettype wire

/* File: tb/trx_regs_props.sv */
// Checker: port-level properties of the register bank
`timescale 1ns/1ps
`default_nettype none
module trx_regs_props
    import trx_pkg::*;
#(
    parameter int POLL_TIMER_CAL_START_CYC = 10,
    parameter int FSK_CAL_START_CYC = 8
) (
    // Clock, reset, register port
    input wire logic                       clk,
    input wire logic                       rstn,
    input wire logic                       ce,
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic [trx_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0]                 reg_wdata,
    input wire logic [7:0]                 reg_rdata,
    input wire logic                       pll_lock_in,
    // Decoded outputs
    input wire logic                       agc_lock_enable,
    input wire logic                       peak_track_force,
    input wire logic                       deep_sleep,
    input wire logic                       fsk_mode,
    input wire logic                       tx_mode,
    input wire logic                       discontinuous_rx_enable,
    input wire logic [1:0]                 off_prescale,
    input wire logic [1:0]                 on_prescale,
    input wire logic [4:0]                 dwell_exponent,
    input wire logic                       poll_cal_busy,
    input wire logic                       fsk_cal_busy,
    input wire logic                       clock_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    localparam int PL = POLL_TIMER_CAL_START_CYC + 3;
    localparam int FL = FSK_CAL_START_CYC + 3;
    logic [7:0] d1;
    logic [7:0] d2;
    logic       wc;
    logic       w0;
    logic       w1;
    // Write data two edges back, when decoded outputs settle
    always_ff @(posedge clk)
    begin
        d1 <= reg_wdata;
        d2 <= d1;
    end
    // Write decodes
    assign wc = reg_wr && ce && reg_addr == ADDR_CONTROL;
    assign w0 = reg_wr && ce && reg_addr == ADDR_CONFIG0;
    assign w1 = reg_wr && ce && reg_addr == ADDR_CONFIG1;

    agc_track_a: assert property (wc |-> ##2 agc_lock_enable == d2[7] && peak_track_force == d2[5])
        else $error("agc lock or tracking output wrong");
    sleep_ctrl_a: assert property (wc && reg_wdata[0] |-> ##2 deep_sleep)
        else $error("deep sleep not entered");
    clk_off_a: assert property (wc && !reg_wdata[1] |-> ##2 !clock_out)
        else $error("clock output not held low");
    mode_fields_a: assert property (w0 |-> ##2 fsk_mode == d2[7]
        && discontinuous_rx_enable == d2[4] && off_prescale == d2[3:2] && on_prescale == d2[1:0])
        else $error("configuration 0 outputs wrong");
    dwell_map_a: assert property (w1 |-> ##2 dwell_exponent == 5'd9 + {1'b0, d2[2:0], 1'b0})
        else $error("dwell exponent wrong");
    tx_force_a: assert property (w0 && reg_wdata[6] && pll_lock_in && $past(pll_lock_in, 4)
        && $past(rstn, 6) |-> ##2 tx_mode)
        else $error("transmit not forced");
    status_zero_a: assert property (reg_rd && ce && reg_addr == ADDR_STATUS |=> reg_rdata[4:2] == 3'h0)
        else $error("status spare bits not zero");
    spare_zero_a: assert property (reg_rd && ce && reg_addr == ADDR_CONFIG1 |=> !reg_rdata[7])
        else $error("config 1 spare bit not zero");
    poll_timer_cal_start_end_a: assert property ($rose(poll_cal_busy) |-> ##[1:PL] !poll_cal_busy)
        else $error("polling calibration never ends");
    fsk_cal_start_end_a: assert property ($rose(fsk_cal_busy) |-> ##[1:FL] !fsk_cal_busy)
        else $error("fsk calibration never ends");
endmodule : trx_regs_props
bind trx_regs trx_regs_props #(.POLL_TIMER_CAL_START_CYC(POLL_TIMER_CAL_START_CYC), .FSK_CAL_START_CYC(FSK_CAL_START_CYC)) chk (.*);
`default_nettype wire
